// ==== core/ext_reg_pkg.sv ====
// Purpose: shared constants and types for the external-transistor regulator control
// Assumes: 40 MHz ref_clk, Avalon-MM register access with byte addresses
// Notes:   offsets are byte addresses of aligned 32-bit words
package ext_reg_pkg;

    // register map, byte addresses
    localparam logic [7:0] MODE_CTRL_OFS   = 8'h00;
    localparam logic [7:0] OPT_OFS         = 8'h04;
    localparam logic [7:0] SUP_STAT2_OFS   = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h0c;
    localparam logic [7:0] LIVE_STAT_OFS   = 8'h10;
    localparam logic [7:0] SOFT_RST_OFS    = 8'h14;

    // mode control register fields
    localparam int STANDALONE_EN_BIT = 0;
    // hardware control register fields
    localparam int LOAD_SHARE_EN_BIT = 0;
    localparam int UV_OVERRIDE_BIT   = 1;
    localparam int STOP_KEEP_ON_BIT  = 2;
    localparam int VOLT_SEL_BIT      = 3;
    localparam int OPT_W             = 4;
    // sticky status / mask fields
    localparam int OC_FLAG_BIT       = 0;
    localparam int UV_FLAG_BIT       = 1;
    localparam int ACCESS_FAIL_BIT   = 2;
    localparam int STAT_W            = 3;
    // live state register fields
    localparam int LIVE_CFG_LSB      = 0;
    localparam int LIVE_ENABLE_BIT   = 2;
    localparam int LIVE_SEL3V3_BIT   = 3;
    localparam int LIVE_HP_BIT       = 4;
    localparam int LIVE_SUPPLY_UV_BIT = 5;
    // soft reset command field
    localparam int SOFT_RST_BIT      = 0;

    // reset values
    localparam logic [OPT_W-1:0]     OPT_RST      = 4'h0;
    localparam logic [STAT_W-1:0]    STAT_RST     = 3'h0;
    localparam logic [STAT_W-1:0]    MASK_RST     = 3'h0;
    localparam logic [31:0]          RDATA_RST    = 32'h0000_0000;

    // analog comparator inputs, all asynchronous to ref_clk
    localparam int ANA_W = 5;
    typedef struct packed {
        logic supply_uv;   // battery_supply_input below supply_undervoltage_threshold
        logic shunt_oc;    // shunt voltage threshold reached
        logic ext_uv;      // regulator output undervoltage comparator
        logic base_rise;   // base current above rising threshold
        logic base_fall;   // base current below falling threshold
    } ana_in_s;

    // regulator drive outputs
    typedef struct packed {
        logic enable;      // pass transistor driver on
        logic sel_3v3;     // 3.3V output level selected
        logic high_power;  // high-power regulation stage on
        logic low_power;   // low-power regulation stage on
    } reg_drive_s;

    // device operating modes, supplied by the mode state machine
    typedef enum logic [2:0] {
        MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
    } sbc_mode_e;

    // locked configuration
    typedef enum logic [1:0] {
        CFG_NONE, CFG_STANDALONE, CFG_LOAD_SHARE
    } cfg_e;

endpackage

// ==== core/input_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for comparator inputs
// Assumes: inputs asynchronous to clk
// Notes:   output moves only when the second and third stages agree
`timescale 1ns/1ps
module input_sync
    import ext_reg_pkg::*;
#(
    parameter int W = ANA_W
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    // raw and filtered levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic stage2_r;
            logic stage3_r;
            logic out_r;

            // first stage feeds only the second
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_r   <= 1'b0;
                    stage2_r <= 1'b0;
                    stage3_r <= 1'b0;
                end else begin
                    meta_r   <= async_in[i];
                    stage2_r <= meta_r;
                    stage3_r <= stage2_r;
                end
            end

            // a glitch seen by one stage only never reaches the logic
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    out_r <= 1'b0;
                end else if (stage2_r == stage3_r) begin
                    out_r <= stage3_r;
                end
            end

            assign sync_out[i] = out_r;
        end
    endgenerate

endmodule

// ==== core/ext_reg_ctrl.sv ====
// Purpose: configuration lock, mode gating and status for the external-transistor regulator
// Assumes: resetn is the power-on reset; sbc_mode comes from logic on ref_clk
// Notes:   Avalon-MM slave, one wait state on every access
//
// Functional notes
// - writing the standalone enable in Normal mode selects standalone configuration
// - writing the load-share enable selects load-sharing configuration
// - first selected configuration is locked; later writes cannot change it
// - locked configuration survives soft reset, held while powered
// - standalone: voltage select clear gives 5.0V, set gives 3.3V
// - load-sharing: voltage select is ignored
// - regulator off below supply undervoltage threshold, back on above it
// - undervoltage override bit keeps regulator on below the threshold
// - Stop mode load-sharing stays on only with the keep-on bit
// - standalone: off in Init/Fail-Safe, switchable in Normal, held elsewhere
// - load-sharing follows main regulator: on in Normal/Restart, off Init/Sleep/Fail-Safe
// - Normal uses high-power stage only; Stop adds it with hysteresis
// - status flags readable in the second supply status register
// - load-sharing locked: change attempt sets access-failure flag, config unchanged
// - standalone locked: on/off still works, no failure flag on change attempt
// - standalone: shunt threshold sets overcurrent flag only; clearable afterwards
// - undervoltage flag only in standalone configuration
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module ext_reg_ctrl
    import ext_reg_pkg::*;
(
    // clock and power-on reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // device state
    input  wire sbc_mode_e   sbc_mode,
    input  wire logic        soft_reset_req,
    // analog comparators
    input  wire ana_in_s     ana_in,
    // regulator drive
    output reg_drive_s       drive,
    output logic             irq,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    // register-decode helper, used by read and write paths
    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
        is_reg = (addr == ofs);
    endfunction

    ana_in_s              ana_s;
    logic                 waitreq_r;
    logic [31:0]          rdata_r;
    logic                 wr_go;
    logic                 rd_go;
    logic                 soft_rst;
    cfg_e                 cfg_r;
    logic                 sa_on_r;
    logic [OPT_W-1:0]     opt_r;
    logic [STAT_W-1:0]    stat_r;
    logic [STAT_W-1:0]    stat_set;
    logic [STAT_W-1:0]    mask_r;
    logic                 hp_stop_r;
    logic                 en_mode;
    logic                 en_nxt;
    logic                 hp_nxt;
    reg_drive_s           drive_r;
    logic                 irq_r;
    logic                 fail_evt;
    logic                 wr_mode;
    logic                 wr_hw;
    logic                 wr_sa_bit;
    logic                 wr_ls_bit;

    input_sync #(.W(ANA_W)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (ana_in),
        .sync_out (ana_s)
    );

    // bus handshake: one wait cycle, accepted where waitrequest is low
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            waitreq_r <= 1'b1;
        end else if ((avs_read || avs_write) && waitreq_r) begin
            waitreq_r <= 1'b0;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    assign wr_go     = avs_write && !waitreq_r && avs_byteenable[0];
    assign rd_go     = avs_read && !waitreq_r;
    assign wr_mode   = wr_go && is_reg(avs_address, MODE_CTRL_OFS);
    assign wr_hw     = wr_go && is_reg(avs_address, OPT_OFS);
    assign wr_sa_bit = avs_writedata[STANDALONE_EN_BIT];
    assign wr_ls_bit = avs_writedata[LOAD_SHARE_EN_BIT];
    // soft reset by pin or by command word; neither touches the lock
    assign soft_rst  = soft_reset_req || (wr_go && is_reg(avs_address, SOFT_RST_OFS)
                                          && avs_writedata[SOFT_RST_BIT]);

    // configuration lock, cleared by power-on reset only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= CFG_NONE;
        end else if (cfg_r == CFG_NONE) begin
            if (wr_hw && wr_ls_bit) begin
                cfg_r <= CFG_LOAD_SHARE;
            end else if (wr_mode && wr_sa_bit && sbc_mode == MODE_NORMAL && !opt_r[LOAD_SHARE_EN_BIT]) begin
                cfg_r <= CFG_STANDALONE;
            end
        end
        // no else: a locked configuration never moves, soft reset included
    end

    // change attempts against a locked load-sharing configuration
    assign fail_evt = (cfg_r == CFG_LOAD_SHARE) && ((wr_mode && wr_sa_bit) || (wr_hw && !wr_ls_bit));

    // standalone on/off bit, switchable in Normal, frozen in the other live modes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sa_on_r <= 1'b0;
        end else if (soft_rst || sbc_mode == MODE_INIT || sbc_mode == MODE_FAILSAFE) begin
            sa_on_r <= 1'b0;
        end else if (wr_mode && sbc_mode == MODE_NORMAL && cfg_r != CFG_LOAD_SHARE) begin
            sa_on_r <= wr_sa_bit;
        end
    end

    // hardware control bits; load-share bit pinned to the locked configuration
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            opt_r <= OPT_RST;
        end else if (soft_rst) begin
            opt_r <= OPT_RST;
            opt_r[LOAD_SHARE_EN_BIT] <= (cfg_r == CFG_LOAD_SHARE);
        end else if (wr_hw) begin
            opt_r <= avs_writedata[OPT_W-1:0];
            if (cfg_r == CFG_LOAD_SHARE) begin
                opt_r[LOAD_SHARE_EN_BIT] <= 1'b1;
            end else if (cfg_r == CFG_STANDALONE) begin
                opt_r[LOAD_SHARE_EN_BIT] <= 1'b0;
            end
        end
    end

    // enable by mode and configuration
    always_comb begin
        en_mode = 1'b0;
        case (cfg_r)
            CFG_STANDALONE: begin
                case (sbc_mode)
                    MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART: en_mode = sa_on_r;
                    default: en_mode = 1'b0;
                endcase
            end
            CFG_LOAD_SHARE: begin
                case (sbc_mode)
                    MODE_NORMAL, MODE_RESTART: en_mode = 1'b1;
                    MODE_STOP: en_mode = opt_r[STOP_KEEP_ON_BIT];
                    default: en_mode = 1'b0;
                endcase
            end
            default: en_mode = 1'b0;
        endcase
    end

    // supply undervoltage cuts the regulator unless overridden
    assign en_nxt = en_mode && (!ana_s.supply_uv || opt_r[UV_OVERRIDE_BIT]);

    // stop-mode high-power stage hysteresis on base current
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hp_stop_r <= 1'b0;
        end else if (sbc_mode != MODE_STOP) begin
            hp_stop_r <= 1'b0;
        end else if (ana_s.base_rise) begin
            hp_stop_r <= 1'b1;
        end else if (ana_s.base_fall) begin
            hp_stop_r <= 1'b0;
        end
    end

    // normal uses only the high-power stage; stop gates it by hysteresis, every other mode keeps it on
    always_comb begin
        case (sbc_mode)
            MODE_NORMAL: hp_nxt = 1'b1;
            MODE_STOP:   hp_nxt = hp_stop_r;
            default:     hp_nxt = 1'b1;
        endcase
    end

    // drive outputs, all registered
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_r <= '0;
        end else begin
            drive_r.enable     <= en_nxt;
            drive_r.sel_3v3    <= (cfg_r == CFG_STANDALONE) && opt_r[VOLT_SEL_BIT];
            drive_r.high_power <= en_nxt && hp_nxt;
            drive_r.low_power  <= en_nxt && (sbc_mode != MODE_NORMAL);
        end
    end

    // events that set sticky flags
    always_comb begin
        stat_set = '0;
        stat_set[OC_FLAG_BIT]     = (cfg_r == CFG_STANDALONE) && ana_s.shunt_oc;
        stat_set[UV_FLAG_BIT]     = (cfg_r == CFG_STANDALONE) && drive_r.enable && ana_s.ext_uv;
        stat_set[ACCESS_FAIL_BIT] = fail_evt;
    end

    // sticky status; a read clears only what it reported, so no event is lost
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stat_r <= STAT_RST;
        end else if (rd_go && is_reg(avs_address, SUP_STAT2_OFS)) begin
            stat_r <= (stat_r & ~rdata_r[STAT_W-1:0]) | stat_set;
        end else begin
            stat_r <= stat_r | stat_set;
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mask_r <= MASK_RST;
        end else if (wr_go && is_reg(avs_address, IRQ_MASK_OFS)) begin
            mask_r <= avs_writedata[STAT_W-1:0];
        end
    end

    // level interrupt while any unmasked flag is set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // read data captured in the wait cycle, stands at the accepting edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= RDATA_RST;
        end else if (avs_read && waitreq_r) begin
            rdata_r <= RDATA_RST;
            if (is_reg(avs_address, MODE_CTRL_OFS)) begin
                rdata_r[STANDALONE_EN_BIT] <= sa_on_r;
            end else if (is_reg(avs_address, OPT_OFS)) begin
                rdata_r[OPT_W-1:0] <= opt_r;
            end else if (is_reg(avs_address, SUP_STAT2_OFS)) begin
                rdata_r[STAT_W-1:0] <= stat_r;
            end else if (is_reg(avs_address, IRQ_MASK_OFS)) begin
                rdata_r[STAT_W-1:0] <= mask_r;
            end else if (is_reg(avs_address, LIVE_STAT_OFS)) begin
                rdata_r[LIVE_CFG_LSB+1:LIVE_CFG_LSB] <= cfg_r;
                rdata_r[LIVE_ENABLE_BIT]    <= drive_r.enable;
                rdata_r[LIVE_SEL3V3_BIT]    <= drive_r.sel_3v3;
                rdata_r[LIVE_HP_BIT]        <= drive_r.high_power;
                rdata_r[LIVE_SUPPLY_UV_BIT] <= ana_s.supply_uv;
            end
            // unmapped addresses read as zero
        end
    end

    assign avs_waitrequest = waitreq_r;
    assign avs_readdata    = rdata_r;
    assign drive           = drive_r;
    assign irq             = irq_r;

endmodule

// ==== tb/pnp_shunt_model.sv ====
// Purpose: behavioural external pass transistor with shunt
// Assumes: comparators settle within one ref_clk cycle
// Notes:   bench commands load, short, output sag and supply drop
`timescale 1ns/1ps
module pnp_shunt_model
    import ext_reg_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // regulator drive and bench commands
    input  wire reg_drive_s drive,
    input  wire logic       load_high,
    input  wire logic       short_on,
    input  wire logic       sag_on,
    input  wire logic       supply_low,
    // comparator levels
    output ana_in_s         ana_out
);
    // shunt and base current only flow while the pass device conducts
    always_ff @(posedge ref_clk) begin
        ana_out.supply_uv <= supply_low;
        ana_out.shunt_oc  <= drive.enable && short_on;
        ana_out.ext_uv    <= drive.enable && sag_on;
        ana_out.base_rise <= drive.enable && load_high;
        ana_out.base_fall <= !(drive.enable && load_high);
    end
endmodule

// ==== tb/ext_reg_ctrl_chk.sv ====
// Purpose: port-level checks for ext_reg_ctrl
// Assumes: one wait state per access, drive one edge after its cause
// Notes:   shadows lock, control bits and mask from accepted writes
`timescale 1ns/1ps
module ext_reg_ctrl_chk
    import ext_reg_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // device state and comparators
    input wire sbc_mode_e   sbc_mode,
    input wire logic        soft_reset_req,
    input wire ana_in_s     ana_in,
    // outputs
    input wire reg_drive_s  drive,
    input wire logic        irq,
    // bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    cfg_e              cfg_r;
    logic [3:1]        hw_r;
    logic [STAT_W-1:0] mask_r;
    logic              wr_ok;
    // a write lands only at the edge where waitrequest is low
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    // shadow lock: first selection wins, only power-on clears it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            cfg_r <= CFG_NONE;
        else if (wr_ok && cfg_r == CFG_NONE && avs_writedata[0] && avs_address == OPT_OFS)
            cfg_r <= CFG_LOAD_SHARE;
        else if (wr_ok && cfg_r == CFG_NONE && avs_writedata[0] && avs_address == MODE_CTRL_OFS
                 && sbc_mode == MODE_NORMAL)
            cfg_r <= CFG_STANDALONE;
    end
    // soft reset wipes control bits but never the lock or the mask
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            hw_r <= '0;
        else if (soft_reset_req || (wr_ok && avs_address == SOFT_RST_OFS && avs_writedata[0]))
            hw_r <= '0;
        else if (wr_ok && avs_address == OPT_OFS)
            hw_r <= avs_writedata[3:1];
    end
    // mask shadow
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            mask_r <= MASK_RST;
        else if (wr_ok && avs_address == IRQ_MASK_OFS)
            mask_r <= avs_writedata[STAT_W-1:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_access; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_one_wait; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_one_wait; s_access |=> s_one_wait; endproperty
    a_one_wait: assert property (p_one_wait) else $error("access without exactly one wait");
    property p_unmapped; avs_read && !avs_waitrequest && avs_address > SOFT_RST_OFS |-> avs_readdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_init_off; (sbc_mode == MODE_INIT || sbc_mode == MODE_FAILSAFE) [*2] |-> !drive.enable; endproperty
    a_init_off: assert property (p_init_off) else $error("regulator on in init or fail-safe");
    property p_normal_stage; (sbc_mode == MODE_NORMAL) [*2] ##0 drive.enable |-> drive.high_power && !drive.low_power; endproperty
    a_normal_stage: assert property (p_normal_stage) else $error("normal mode stage wrong");
    property p_ls_sleep; (cfg_r == CFG_LOAD_SHARE && sbc_mode == MODE_SLEEP) [*2] |-> !drive.enable; endproperty
    a_ls_sleep: assert property (p_ls_sleep) else $error("load share on in sleep");
    property p_ls_stop; (cfg_r == CFG_LOAD_SHARE && sbc_mode == MODE_STOP && !hw_r[STOP_KEEP_ON_BIT]) [*2] |-> !drive.enable; endproperty
    a_ls_stop: assert property (p_ls_stop) else $error("load share on in stop without keep");
    property p_ls_no_sel; (cfg_r == CFG_LOAD_SHARE) [*2] |-> !drive.sel_3v3; endproperty
    a_ls_no_sel: assert property (p_ls_no_sel) else $error("voltage select used in load share");
    property p_uv_off; (ana_in.supply_uv && !hw_r[UV_OVERRIDE_BIT]) [*8] |-> !drive.enable; endproperty
    a_uv_off: assert property (p_uv_off) else $error("regulator on under supply undervoltage");
    property p_uv_keep; (cfg_r == CFG_LOAD_SHARE && sbc_mode == MODE_NORMAL && hw_r[UV_OVERRIDE_BIT]) [*8] |-> drive.enable; endproperty
    a_uv_keep: assert property (p_uv_keep) else $error("override did not keep regulator on");
    property p_sel; (cfg_r == CFG_STANDALONE) [*2] ##0 $stable(hw_r) ##0 drive.enable |-> drive.sel_3v3 == hw_r[VOLT_SEL_BIT]; endproperty
    a_sel: assert property (p_sel) else $error("output level does not follow select");
    property p_irq_mask; (mask_r == '0) [*2] |-> !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while fully masked");
endmodule
bind ext_reg_ctrl ext_reg_ctrl_chk i_chk (
    .ref_clk(ref_clk), .resetn(resetn), .sbc_mode(sbc_mode), .soft_reset_req(soft_reset_req),
    .ana_in(ana_in), .drive(drive), .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

// ==== tb/test_ext_reg_ctrl.sv ====
// Purpose: self-checking bench for ext_reg_ctrl
// Assumes: one wait state per access, comparator path under eight cycles
// Notes:   a second power-on reset covers the load-sharing configuration
`timescale 1ns/1ps
module test_ext_reg_ctrl
    import ext_reg_pkg::*;
;
    logic        ref_clk, resetn, soft_reset_req, irq, avs_read, avs_write, avs_waitrequest;
    logic        load_high, short_on, sag_on, supply_low;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    sbc_mode_e   sbc_mode;
    ana_in_s     ana_in;
    reg_drive_s  drive;
    int          bad_count, n_compared;
    // mode walk and expected enable per configuration
    sbc_mode_e   walk_m[4] = '{MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE, MODE_NORMAL};
    logic        sa_e[4]   = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic        ls_e[4]   = '{1'b0, 1'b1, 1'b0, 1'b1};

    ext_reg_ctrl i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .sbc_mode(sbc_mode), .soft_reset_req(soft_reset_req),
        .ana_in(ana_in), .drive(drive), .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );
    pnp_shunt_model i_pnp (
        .ref_clk(ref_clk), .drive(drive), .load_high(load_high), .short_on(short_on),
        .sag_on(sag_on), .supply_low(supply_low), .ana_out(ana_in)
    );

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one access; held until waitrequest is seen low, bounded wait
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            check(32'h1, 32'h0);
            close_out();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        check(q & m, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic mode_chk(input sbc_mode_e m, input logic exp);
        @(posedge ref_clk);
        sbc_mode <= m;
        idle(3);
        check(drive.enable, exp);
    endtask
    // power-on reset, six cycles, mode back to init
    task automatic power_up();
        @(posedge ref_clk);
        resetn <= 1'b0;
        sbc_mode <= MODE_INIT;
        idle(6);
        resetn <= 1'b1;
    endtask

    initial begin
        {resetn, soft_reset_req, avs_read, avs_write, load_high, short_on, sag_on, supply_low} = '0;
        avs_address = '0;
        avs_writedata = '0;
        sbc_mode = MODE_INIT;
        bad_count = 0;
        n_compared = 0;
        power_up();
        rd_chk(LIVE_STAT_OFS, 32'h3, 32'h0);
        rd_chk(SUP_STAT2_OFS, 32'hffff_ffff, 32'h0);
        rd_chk(8'h18, 32'hffff_ffff, 32'h0);
        // selection outside normal mode must not take
        wr(MODE_CTRL_OFS, 32'h1);
        rd_chk(LIVE_STAT_OFS, 32'h7, 32'h0);
        mode_chk(MODE_NORMAL, 1'b0);
        wr(OPT_OFS, 32'h8);
        wr(MODE_CTRL_OFS, 32'h1);
        idle(3);
        rd_chk(LIVE_STAT_OFS, 32'h1f, 32'h1d);
        check(drive, 4'he);
        // load-share attempt after standalone lock: configuration unchanged, voltage select cleared, no failure flag
        wr(OPT_OFS, 32'h1);
        idle(3);
        rd_chk(SUP_STAT2_OFS, 32'h4, 32'h0);
        rd_chk(LIVE_STAT_OFS, 32'h1f, 32'h15);
        // stop mode adds the high-power stage with hysteresis
        mode_chk(MODE_STOP, 1'b1);
        load_high <= 1'b1;
        idle(8);
        check({drive.high_power, drive.low_power}, 2'b11);
        load_high <= 1'b0;
        idle(8);
        check({drive.high_power, drive.low_power}, 2'b01);
        foreach (walk_m[i]) mode_chk(walk_m[i], sa_e[i]);
        wr(MODE_CTRL_OFS, 32'h1);
        idle(3);
        check(drive.enable, 1'b1);
        supply_low <= 1'b1;
        idle(10);
        check(drive.enable, 1'b0);
        rd_chk(LIVE_STAT_OFS, 32'h24, 32'h20);
        wr(OPT_OFS, 32'h2);
        idle(3);
        check(drive.enable, 1'b1);
        supply_low <= 1'b0;
        wr(OPT_OFS, 32'h0);
        idle(8);
        check(drive.enable, 1'b1);
        // overcurrent: masked first, then unmasked, cleared once gone
        short_on <= 1'b1;
        idle(8);
        check(irq, 1'b0);
        wr(IRQ_MASK_OFS, 32'h1);
        idle(2);
        check({irq, drive.enable}, 2'b11);
        short_on <= 1'b0;
        idle(8);
        rd_chk(SUP_STAT2_OFS, 32'h7, 32'h1);
        rd_chk(SUP_STAT2_OFS, 32'h7, 32'h0);
        idle(2);
        check(irq, 1'b0);
        sag_on <= 1'b1;
        idle(8);
        sag_on <= 1'b0;
        idle(8);
        rd_chk(SUP_STAT2_OFS, 32'h2, 32'h2);
        soft_reset_req <= 1'b1;
        @(posedge ref_clk);
        soft_reset_req <= 1'b0;
        idle(3);
        rd_chk(LIVE_STAT_OFS, 32'h7, 32'h1);
        // second power-up: load-sharing selected in init
        power_up();
        rd_chk(LIVE_STAT_OFS, 32'h3, 32'h0);
        wr(OPT_OFS, 32'h9);
        idle(3);
        rd_chk(LIVE_STAT_OFS, 32'h7, 32'h2);
        mode_chk(MODE_NORMAL, 1'b1);
        check(drive, 4'ha);
        wr(MODE_CTRL_OFS, 32'h1);
        rd_chk(SUP_STAT2_OFS, 32'h4, 32'h4);
        wr(OPT_OFS, 32'h8);
        rd_chk(SUP_STAT2_OFS, 32'h4, 32'h4);
        rd_chk(LIVE_STAT_OFS, 32'h3, 32'h2);
        sag_on <= 1'b1;
        idle(8);
        sag_on <= 1'b0;
        idle(8);
        rd_chk(SUP_STAT2_OFS, 32'h2, 32'h0);
        mode_chk(MODE_STOP, 1'b0);
        wr(OPT_OFS, 32'hd);
        idle(3);
        check(drive.enable, 1'b1);
        foreach (walk_m[i]) mode_chk(walk_m[i], ls_e[i]);
        wr(OPT_OFS, 32'hb);
        supply_low <= 1'b1;
        idle(10);
        check(drive.enable, 1'b1);
        supply_low <= 1'b0;
        wr(SOFT_RST_OFS, 32'h1);
        idle(3);
        rd_chk(LIVE_STAT_OFS, 32'h3, 32'h2);
        close_out();
    end
endmodule
